// File: design/rstc_pkg.sv
package rstc_pkg;

   localparam int          DATA_W         = 8;
   localparam int          ADDR_W         = 8;
   localparam int          CNT_W          = 24;

   localparam int          CLOCK_MHZ      = 25;
   localparam int          INIT_TIME_US   = 250;
   localparam int          SCAN_KB_US     = 500;
   localparam int          INIT_CYCLES    = INIT_TIME_US * CLOCK_MHZ;
   localparam int          SCAN_KB_CYCLES = SCAN_KB_US * CLOCK_MHZ;
   localparam int          SUT_STEP_CYC   = 1600;
   localparam int          UNLOCK_INSNS   = 4;

   localparam logic [ADDR_W-1:0] ADDR_CAUSE   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_TRIGGER = 8'h01;

   localparam int          FLAG_POR       = 0;
   localparam int          FLAG_BOD       = 1;
   localparam int          FLAG_EXT       = 2;
   localparam int          FLAG_WDT       = 3;
   localparam int          FLAG_SW        = 4;
   localparam int          FLAG_DBG       = 5;
   localparam int          FLAG_W         = 6;
   localparam int          TRIGGER_BIT    = 0;

   localparam logic [FLAG_W-1:0] FLAGS_AFTER_POR = 6'h01;
   localparam logic [FLAG_W-1:0] FLAGS_NONE      = 6'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO       = 8'h00;
   localparam logic [2:0]        UNLOCK_CLOSED   = 3'h0;
   localparam logic [2:0]        UNLOCK_OPEN     = 3'h4;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_HOLD = 2'b01,
      ST_INIT = 2'b10
   } rstc_state_type;

   typedef struct packed {
      logic power_on;
      logic brownout;
      logic ext_reset_n;
      logic watchdog;
      logic debug_port;
   } rstc_sources_type;

   typedef struct packed {
      logic       ext_reset_en;
      logic [2:0] start_up_time_fuse;
      logic       memory_scan_source_fuse;
      logic [3:0] scan_kbytes;
   } rstc_fuses_type;

   typedef struct packed {
      logic core;
      logic debug_port;
      logic config_keep;
      logic override_off;
      logic fuse_reload;
   } rstc_resets_type;

endpackage : rstc_pkg

// File: design/rstc_reset_controller.sv
module rstc_reset_controller
   import rstc_pkg::*;
#(
   parameter int INIT_CYC     = INIT_CYCLES,
   parameter int SCAN_KB_CYC  = SCAN_KB_CYCLES,
   parameter int SUT_STEP_CYC_P = SUT_STEP_CYC
) (
   input  wire logic                     clock,
   input  wire logic                     srst,
   input  wire rstc_pkg::rstc_sources_type sources,
   input  wire rstc_pkg::rstc_fuses_type fuses,
   input  wire logic                     unlock_key_written,
   input  wire logic                     instruction_done,
   input  wire logic [rstc_pkg::ADDR_W-1:0] addr,
   input  wire logic [rstc_pkg::DATA_W-1:0] wdata,
   input  wire logic                     wr_stb,
   input  wire logic                     rd_stb,
   output rstc_pkg::rstc_resets_type     resets,
   output logic [rstc_pkg::DATA_W-1:0]   rdata
);
   import rstc_pkg::*;

   rstc_state_type         state_q, state_d;
   logic [CNT_W-1:0]       cnt_q, cnt_d;
   logic                   scope_dbg_q, scope_dbg_d;
   logic                   scope_cfg_q, scope_cfg_d;
   logic                   boot_pending_q, boot_pending_d;
   rstc_fuses_type         fuse_q, fuse_d;
   rstc_resets_type        resets_q, resets_d;
   logic [FLAG_W-1:0]      flags_q, flags_d;
   logic [2:0]             unlock_q, unlock_d;
   logic [DATA_W-1:0]      rdata_q, rdata_d;

   logic                   ext_active;
   logic                   level_active;
   logic                   sw_request;
   logic                   any_request;
   logic                   trig_write;
   logic [FLAG_W-1:0]      flag_set;
   logic [FLAG_W-1:0]      flag_clr;
   logic [CNT_W-1:0]       init_total;

   // pin reset only counts when the fuse copy enables it
   assign ext_active   = fuse_q.ext_reset_en & ~sources.ext_reset_n;
   assign level_active = sources.power_on | sources.brownout | ext_active
                         | sources.debug_port;
   assign trig_write   = wr_stb & (addr == ADDR_TRIGGER);
   // protected write only acts inside the unlock window
   assign sw_request   = trig_write & wdata[TRIGGER_BIT]
                         & (unlock_q != UNLOCK_CLOSED);
   assign any_request  = level_active | sources.watchdog | sw_request;

   // init time: base plus start-up fuse steps plus optional scan per kilobyte
   // taken from the live fuses, as the copy follows them a cycle late while held
   assign init_total = CNT_W'(INIT_CYC)
                     + CNT_W'(fuses.start_up_time_fuse) * CNT_W'(SUT_STEP_CYC_P)
                     + (fuses.memory_scan_source_fuse
                        ? CNT_W'(fuses.scan_kbytes) * CNT_W'(SCAN_KB_CYC)
                        : CNT_W'(0));

   // sequencer: no clock gating or sleep input, so it runs in every mode
   always_comb begin
      state_d        = state_q;
      cnt_d          = cnt_q;
      scope_dbg_d    = scope_dbg_q;
      scope_cfg_d    = scope_cfg_q;
      boot_pending_d = boot_pending_q;
      fuse_d         = fuse_q;
      case (state_q)
         ST_RUN: begin
            if (any_request) begin
               state_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // fuse copies follow the fuses while held, so release loads fresh values
            fuse_d = fuses;
            if (!level_active) begin
               state_d = ST_INIT;
               cnt_d   = init_total;
            end
         end
         ST_INIT: begin
            if (any_request) begin
               state_d = ST_HOLD;
            end else if (cnt_q <= CNT_W'(1)) begin
               state_d        = ST_RUN;
               boot_pending_d = 1'b0;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         default: begin
            state_d = ST_HOLD;
         end
      endcase
      if (state_d == ST_RUN) begin
         scope_dbg_d = 1'b0;
         scope_cfg_d = 1'b0;
      end else begin
         // widest scope seen since entering reset decides what is held
         if (sources.power_on || sources.brownout) begin
            scope_dbg_d = 1'b1;
         end
         if (sources.power_on) begin
            scope_cfg_d    = 1'b1;
            boot_pending_d = 1'b1;
         end
      end
   end

   always_comb begin
      resets_d.core         = (state_d != ST_RUN);
      resets_d.debug_port   = (state_d != ST_RUN) & scope_dbg_d;
      resets_d.config_keep  = (state_d != ST_RUN) & scope_cfg_d;
      resets_d.override_off = sources.power_on;
      resets_d.fuse_reload  = (state_q == ST_HOLD) & (state_d == ST_INIT);
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_q        <= ST_HOLD;
         cnt_q          <= '0;
         scope_dbg_q    <= 1'b1;
         scope_cfg_q    <= 1'b1;
         boot_pending_q <= 1'b1;
         fuse_q         <= '0;
         resets_q       <= '1;
      end else begin
         state_q        <= state_d;
         cnt_q          <= cnt_d;
         scope_dbg_q    <= scope_dbg_d;
         scope_cfg_q    <= scope_cfg_d;
         boot_pending_q <= boot_pending_d;
         fuse_q         <= fuse_d;
         resets_q       <= resets_d;
      end
   end

   // cause flags: a set in the same cycle as a clear wins, but sets are dropped while boot_pending_q is high
   always_comb begin
      flag_set           = FLAGS_NONE;
      flag_set[FLAG_BOD] = sources.brownout;
      flag_set[FLAG_EXT] = ext_active;
      flag_set[FLAG_WDT] = sources.watchdog;
      flag_set[FLAG_SW]  = sw_request;
      flag_set[FLAG_DBG] = sources.debug_port;
      flag_clr = FLAGS_NONE;
      if (wr_stb && addr == ADDR_CAUSE) begin
         flag_clr = wdata[FLAG_W-1:0];
      end
      if (sources.power_on) begin
         flags_d = FLAGS_AFTER_POR;
      end else if (boot_pending_q) begin
         flags_d = flags_q & ~flag_clr;
      end else begin
         flags_d = (flags_q & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         flags_q <= FLAGS_AFTER_POR;
      end else begin
         flags_q <= flags_d;
      end
   end

   // unlock window counts retired instructions; a trigger write closes it unless the key is written in the same cycle
   always_comb begin
      unlock_d = unlock_q;
      if (unlock_key_written) begin
         unlock_d = UNLOCK_OPEN;
      end else if (trig_write) begin
         unlock_d = UNLOCK_CLOSED;
      end else if (instruction_done && unlock_q != UNLOCK_CLOSED) begin
         unlock_d = unlock_q - 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         unlock_q <= UNLOCK_CLOSED;
      end else begin
         unlock_q <= unlock_d;
      end
   end

   // read data stands only in the cycle after the strobe
   always_comb begin
      rdata_d = DATA_ZERO;
      if (rd_stb) begin
         if (addr == ADDR_CAUSE) begin
            rdata_d = {{(DATA_W-FLAG_W){1'b0}}, flags_q};
         end else if (addr == ADDR_TRIGGER) begin
            rdata_d = DATA_ZERO;
         end else begin
            rdata_d = DATA_ZERO;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_q <= DATA_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign resets = resets_q;
   assign rdata  = rdata_q;

endmodule : rstc_reset_controller

// File: verif/rstc_monitor.sv
module rstc_monitor
   import rstc_pkg::*;
#(
   parameter int INIT_CYC       = 20,
   parameter int SCAN_KB_CYC    = 8,
   parameter int SUT_STEP_CYC_P = 4
) (
   input wire logic                       clock,
   input wire logic                       srst,
   input wire rstc_pkg::rstc_sources_type sources,
   input wire rstc_pkg::rstc_fuses_type   fuses,
   input wire logic                       unlock_key_written,
   input wire logic                       instruction_done,
   input wire logic [7:0]                 addr,
   input wire logic [7:0]                 wdata,
   input wire logic                       wr_stb,
   input wire logic                       rd_stb,
   input wire rstc_pkg::rstc_resets_type  resets,
   input wire logic [7:0]                 rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);
   sequence unlocked_write;
      unlock_key_written ##1 (wr_stb && addr == ADDR_TRIGGER && wdata[0]);
   endsequence
   trig_reads_zero_a: assert property (rd_stb && addr == ADDR_TRIGGER |=> rdata == DATA_ZERO)
      else $error("trigger read nonzero");
   top_bits_a: assert property (rd_stb |=> rdata[7:6] == 2'h0)
      else $error("cause bits 7:6 nonzero");
   brownout_scope_a: assert property (sources.brownout |=> resets.core && resets.debug_port)
      else $error("brownout reset scope wrong");
   debug_scope_a: assert property (sources.debug_port && !resets.core |=>
      resets.core && !resets.config_keep) else $error("debug reset scope wrong");
   wdt_core_a: assert property (sources.watchdog |=> resets.core)
      else $error("watchdog reset missing");
   sw_reset_a: assert property (unlocked_write |=> resets.core)
      else $error("software reset missing");
   override_off_a: assert property (sources.power_on |=> resets.override_off)
      else $error("override not disabled");
   reload_pulse_a: assert property ($rose(resets.fuse_reload) |=> !resets.fuse_reload)
      else $error("reload not a pulse");
   init_hold_a: assert property (resets.fuse_reload |=> resets.core [*8])
      else $error("init too short");
   core_release_a: assert property ($fell(resets.core) |->
      !$past(sources.brownout) && !$past(sources.debug_port)) else $error("early release");
endmodule : rstc_monitor

bind rstc_reset_controller rstc_monitor #(
   .INIT_CYC(INIT_CYC), .SCAN_KB_CYC(SCAN_KB_CYC), .SUT_STEP_CYC_P(SUT_STEP_CYC_P)
) mon_u (
   .clock(clock), .srst(srst), .sources(sources), .fuses(fuses),
   .unlock_key_written(unlock_key_written), .instruction_done(instruction_done),
   .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .resets(resets), .rdata(rdata)
);

// File: verif/rstc_reset_controller_bench.sv
module rstc_reset_controller_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import rstc_pkg::*;
   logic clock = 0, srst = 1, wr_stb = 0, rd_stb = 0, unlock_go = 0;
   logic [7:0] addr = 0, wdata = 0, rv;
   logic [3:0] req = 0;
   rstc_fuses_type fuses = 0;
   rstc_sources_type sources;
   rstc_resets_type resets;
   logic ukw, idone;
   logic [7:0] rdata;
   int mismatches = 0, tests_run = 0, n;
   int flag_pos[4] = '{FLAG_BOD, FLAG_EXT, FLAG_WDT, FLAG_DBG};
   always #20 clock = !clock;
   rstc_source_model src_u (.clock(clock), .srst(srst), .req(req), .unlock_go(unlock_go),
      .sources(sources), .unlock_key_written(ukw), .instruction_done(idone));
   rstc_reset_controller #(.INIT_CYC(20), .SCAN_KB_CYC(8), .SUT_STEP_CYC_P(4)) dut_u (
      .clock(clock), .srst(srst), .sources(sources), .fuses(fuses),
      .unlock_key_written(ukw), .instruction_done(idone), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .resets(resets), .rdata(rdata));
   function automatic int init_len(rstc_fuses_type f);
      return 20 + f.start_up_time_fuse * 4 + (f.memory_scan_source_fuse ? f.scan_kbytes * 8 : 0);
   endfunction : init_len
   task automatic print_verdict();
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
      tests_run++;
      if (v !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", s, e, v);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1 rv = rdata;
   endtask : rd
   task automatic seq_len();
      int k;
      k = 0;
      #1;
      while (resets.fuse_reload !== 1'b1) begin
         @(posedge clock);
         #1 k++;
         if (k > 99) begin
            mismatches++;
            print_verdict();
         end
      end
      n = 0;
      while (resets.core === 1'b1 && n < 400) begin
         n++;
         @(posedge clock);
         #1;
      end
      if (n >= 400) begin
         mismatches++;
         print_verdict();
      end
   endtask : seq_len
   task automatic unlock();
      @(posedge clock);
      unlock_go <= 1'b1;
      @(posedge clock);
      unlock_go <= 1'b0;
   endtask : unlock
   initial begin
      void'($urandom(32'h6A3B));
      fuses <= {1'b1, 8'($urandom)};
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      // power-on outlasts srst by a cycle, so the reload pulse follows two edges later
      repeat (2) @(posedge clock);
      seq_len();
      chk("init", 8'(init_len(fuses)), 8'(n));
      rd(ADDR_CAUSE);
      chk("por flags", 8'h01, rv);
      wr(ADDR_CAUSE, 8'h00);
      rd(ADDR_CAUSE);
      chk("zero write", 8'h01, rv);
      wr(ADDR_CAUSE, 8'hFF);
      rd(ADDR_CAUSE);
      chk("cleared", 8'h00, rv);
      for (int i = 0; i < 4; i++) begin
         fuses <= {1'b1, 8'($urandom)};
         @(posedge clock);
         req[i] <= 1'b1;
         repeat (1 + $urandom_range(2)) @(posedge clock);
         req[i] <= 1'b0;
         @(posedge clock);
         #1 chk("scope", {5'h0, 1'b1, i == 0, 1'b0},
            {5'h0, resets.core, resets.debug_port, resets.config_keep});
         seq_len();
         chk("init", 8'(init_len(fuses)), 8'(n));
         rd(ADDR_CAUSE);
         chk("cause", 8'h01 << flag_pos[i], rv);
         wr(ADDR_CAUSE, 8'hFF);
      end
      unlock();
      repeat (6) @(posedge clock);
      wr(ADDR_TRIGGER, 8'h01);
      @(posedge clock);
      #1 chk("late write", 8'h00, {7'h0, resets.core});
      unlock();
      wr(ADDR_TRIGGER, 8'h01);
      @(posedge clock);
      #1 chk("sw reset", 8'h01, {7'h0, resets.core});
      seq_len();
      rd(ADDR_CAUSE);
      chk("sw cause", 8'h10, rv);
      rd(ADDR_TRIGGER);
      chk("trigger", 8'h00, rv);
      rd(8'h07);
      chk("unmapped", 8'h00, rv);
      print_verdict();
   end
endmodule : rstc_reset_controller_bench

// File: verif/rstc_source_model.sv
module rstc_source_model
   import rstc_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 srst,
   input  wire logic [3:0]           req,
   input  wire logic                 unlock_go,
   output rstc_pkg::rstc_sources_type sources,
   output logic                      unlock_key_written,
   output logic                      instruction_done
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clock) begin
      sources.power_on    <= srst; // supply event outlasts srst by a cycle
      sources.brownout    <= req[0];
      sources.ext_reset_n <= !req[1]; // pin idles high
      sources.watchdog    <= req[2];
      sources.debug_port  <= req[3]; // only the debugger raises this
      unlock_key_written  <= unlock_go; // key precedes the protected write
      instruction_done    <= !srst; // one instruction a cycle closes the window
   end
endmodule : rstc_source_model
